// [src/scsu_pkg.sv]
// Package: opcodes, field positions, widths and operation codes of the execute slice
package scsu_pkg;
  localparam int WORD_W = 32;
  localparam int DWORD_W = 64;
  localparam int REG_IDX_W = 5;
  localparam int SHAMT_W = 5;
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int SRCA_MSB = 25;
  localparam int SRCA_LSB = 21;
  localparam int SRCB_MSB = 20;
  localparam int SRCB_LSB = 16;
  localparam int DST_MSB = 15;
  localparam int DST_LSB = 11;
  localparam int SHAMT_MSB = 10;
  localparam int SHAMT_LSB = 6;
  localparam int FN_MSB = 5;
  localparam int FN_LSB = 0;
  localparam int IMM_MSB = 15;
  localparam int IMM_LSB = 0;
  localparam logic [5:0] OPC_REGISTER_OP_GROUP = 6'h00;
  localparam logic [5:0] OPC_SIGNED_LESS_IMM = 6'h0a;
  localparam logic [5:0] OPC_UNSIGNED_LESS_IMM = 6'h0b;
  localparam logic [5:0] FN_LEFT_SHIFT_VAR = 6'h04;
  localparam logic [5:0] FN_LOGIC_RIGHT_IMM = 6'h02;
  localparam logic [5:0] FN_ARITH_RIGHT_IMM = 6'h03;
  localparam logic [5:0] FN_LOGIC_RIGHT_VAR = 6'h06;
  localparam logic [5:0] FN_ARITH_RIGHT_VAR = 6'h07;
  localparam logic [5:0] FN_SIGNED_LESS = 6'h2a;
  localparam logic [5:0] FN_UNSIGNED_LESS = 6'h2b;
  localparam logic [5:0] FN_DIFFERENCE_TRAP = 6'h22;
  localparam logic [5:0] FN_DIFFERENCE_NO_TRAP = 6'h23;
  localparam logic [63:0] WB_DATA_RST = 64'h0;
  localparam logic [4:0] WB_IDX_RST = 5'h0;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_LEFT_SHIFT_VAR = 4'h1,
    OP_LOGIC_RIGHT_SHIFT_IMM = 4'h2,
    OP_ARITH_RIGHT_SHIFT_IMM = 4'h3,
    OP_LOGIC_RIGHT_SHIFT_VAR = 4'h4,
    OP_ARITH_RIGHT_SHIFT_VAR = 4'h5,
    OP_SIGNED_LESS_FLAG = 4'h6,
    OP_UNSIGNED_LESS_FLAG = 4'h7,
    OP_SIGNED_LESS_IMM_FLAG = 4'h8,
    OP_UNSIGNED_LESS_IMM_FLAG = 4'h9,
    OP_DIFFERENCE_TRAP = 4'ha,
    OP_DIFFERENCE_NO_TRAP = 4'hb
  } alu_op_t;
endpackage : scsu_pkg

// [src/alu_lane_if.sv]
// Interface: operands and results passed between the slice and its two units
`timescale 1ns/1ps
interface alu_lane_if;
  import scsu_pkg::*;
  alu_op_t op;
  logic [63:0] opnd_a;
  logic [63:0] opnd_b;
  logic [4:0] amount;
  logic mode64;
  logic [63:0] shift_res;
  logic [63:0] cmp_res;
  logic [63:0] diff_res;
  logic ovf;
  modport issue_mp(output op, opnd_a, opnd_b, amount, mode64,
                   input shift_res, cmp_res, diff_res, ovf);
  modport shift_mp(input op, opnd_b, amount, mode64, output shift_res);
  modport arith_mp(input op, opnd_a, opnd_b, mode64, output cmp_res, diff_res, ovf);
endinterface : alu_lane_if

// [src/shift_unit.sv]
// Shift unit: 32-bit word shifts, sign-extended into 64 bits in 64-bit mode
`timescale 1ns/1ps
module shift_unit
  import scsu_pkg::*;
(
  alu_lane_if.shift_mp lane
);
  logic [31:0] word;

  always_comb begin
    unique case (lane.op)
      OP_LEFT_SHIFT_VAR: word = lane.opnd_b[31:0] << lane.amount;
      OP_LOGIC_RIGHT_SHIFT_IMM,
      OP_LOGIC_RIGHT_SHIFT_VAR: word = lane.opnd_b[31:0] >> lane.amount;
      OP_ARITH_RIGHT_SHIFT_IMM,
      OP_ARITH_RIGHT_SHIFT_VAR: word = 32'($signed(lane.opnd_b[31:0]) >>> lane.amount);
      default: word = 32'h0;
    endcase
  end

  // Upper half taken from word bit 31 in 64-bit mode and zero in 32-bit mode, so a badly extended operand still yields a clean word
  assign lane.shift_res = lane.mode64 ? {{32{word[31]}}, word} : {32'h0, word};

endmodule : shift_unit

// [src/arith_unit.sv]
// Arithmetic unit: set-on-less-than compares and 32-bit subtract with overflow detect
`timescale 1ns/1ps
module arith_unit
  import scsu_pkg::*;
(
  alu_lane_if.arith_mp lane
);
  logic [32:0] full_sum;
  logic [31:0] low_sum;
  logic carry30;
  logic carry31;
  logic lt_signed;
  logic lt_unsigned;
  logic is_signed;
  logic is_unsigned;

  // Subtract as a + ~b + 1 so both carries are visible
  assign full_sum = {1'h0, lane.opnd_a[31:0]} + {1'h0, ~lane.opnd_b[31:0]} + 33'h1;
  assign low_sum = {1'h0, lane.opnd_a[30:0]} + {1'h0, ~lane.opnd_b[30:0]} + 32'h1;
  assign carry30 = low_sum[31];
  assign carry31 = full_sum[32];
  assign lane.ovf = (lane.op == OP_DIFFERENCE_TRAP) && (carry30 ^ carry31);
  assign lane.diff_res = lane.mode64 ? {{32{full_sum[31]}}, full_sum[31:0]}
                                     : {32'h0, full_sum[31:0]};

  // Direct magnitude compare, never via the difference, so overflow cannot corrupt it
  always_comb begin
    if (lane.mode64) begin
      lt_signed = $signed(lane.opnd_a) < $signed(lane.opnd_b);
      lt_unsigned = lane.opnd_a < lane.opnd_b;
    end else begin
      lt_signed = $signed(lane.opnd_a[31:0]) < $signed(lane.opnd_b[31:0]);
      lt_unsigned = lane.opnd_a[31:0] < lane.opnd_b[31:0];
    end
  end

  assign is_signed = (lane.op == OP_SIGNED_LESS_FLAG) || (lane.op == OP_SIGNED_LESS_IMM_FLAG);
  assign is_unsigned = (lane.op == OP_UNSIGNED_LESS_FLAG)
                    || (lane.op == OP_UNSIGNED_LESS_IMM_FLAG);
  assign lane.cmp_res = {63'h0, (is_signed && lt_signed) || (is_unsigned && lt_unsigned)};

endmodule : arith_unit

// [src/shift_compare_subtract_unit.sv]
// Execute slice: shifts, set-on-less-than and subtract, one result per cycle
// Notes on behaviour
// - Variable left shift by source A low five bits, zeros fill low bits.
// - 64-bit mode sign-extends the left shift word for every amount.
// - Signed less-than writes one or zero, all upper bits zero.
// - Compares never trap and stay correct when the difference overflows.
// - Immediate signed compare sign-extends immediate, writes into source B field.
// - Unsigned compares treat operands, including sign-extended immediate, as unsigned.
// - Arithmetic right shifts replicate bit 31, immediate or variable amount.
// - Logical right shifts fill vacated high bits with zeros.
// - Trapping subtract flags overflow when carries out of bits 30, 31 differ.
// - On that overflow the destination write is suppressed.
// - Non-trapping subtract gives the same difference and never traps.
// - 64-bit mode subtract result is sign-extended from bit 31.
`timescale 1ns/1ps
module shift_compare_subtract_unit
  import scsu_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_src_a,
  input wire logic [63:0] i_src_b,
  input wire logic i_mode64,
  output logic o_done,
  output logic o_wb_en,
  output logic [4:0] o_wb_idx,
  output logic [63:0] o_wb_data,
  output logic o_ovf_exc,
  output logic o_not_handled
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  alu_lane_if lane();
  alu_op_t dec_op;
  logic [5:0] opcode;
  logic [5:0] funct;
  logic [63:0] imm_sext;
  logic is_imm_form;
  logic is_var_shift;

  assign opcode = i_instr[OPC_MSB:OPC_LSB];
  assign funct = i_instr[FN_MSB:FN_LSB];
  assign imm_sext = {{48{i_instr[IMM_MSB]}}, i_instr[IMM_MSB:IMM_LSB]};

  always_comb begin
    dec_op = OP_NONE;
    if (opcode == OPC_REGISTER_OP_GROUP) begin
      unique case (funct)
        FN_LEFT_SHIFT_VAR: dec_op = OP_LEFT_SHIFT_VAR;
        FN_LOGIC_RIGHT_IMM: dec_op = OP_LOGIC_RIGHT_SHIFT_IMM;
        FN_ARITH_RIGHT_IMM: dec_op = OP_ARITH_RIGHT_SHIFT_IMM;
        FN_LOGIC_RIGHT_VAR: dec_op = OP_LOGIC_RIGHT_SHIFT_VAR;
        FN_ARITH_RIGHT_VAR: dec_op = OP_ARITH_RIGHT_SHIFT_VAR;
        FN_SIGNED_LESS: dec_op = OP_SIGNED_LESS_FLAG;
        FN_UNSIGNED_LESS: dec_op = OP_UNSIGNED_LESS_FLAG;
        FN_DIFFERENCE_TRAP: dec_op = OP_DIFFERENCE_TRAP;
        FN_DIFFERENCE_NO_TRAP: dec_op = OP_DIFFERENCE_NO_TRAP;
        default: dec_op = OP_NONE;
      endcase
    end else if (opcode == OPC_SIGNED_LESS_IMM) begin
      dec_op = OP_SIGNED_LESS_IMM_FLAG;
    end else if (opcode == OPC_UNSIGNED_LESS_IMM) begin
      dec_op = OP_UNSIGNED_LESS_IMM_FLAG;
    end
  end

  assign is_imm_form = (dec_op == OP_SIGNED_LESS_IMM_FLAG)
                    || (dec_op == OP_UNSIGNED_LESS_IMM_FLAG);
  assign is_var_shift = (dec_op == OP_LEFT_SHIFT_VAR)
                     || (dec_op == OP_LOGIC_RIGHT_SHIFT_VAR)
                     || (dec_op == OP_ARITH_RIGHT_SHIFT_VAR);

  assign lane.op = dec_op;
  assign lane.opnd_a = i_src_a;
  assign lane.opnd_b = is_imm_form ? imm_sext : i_src_b;
  // Immediate shifts never read source A, so a stale register value cannot leak in
  assign lane.amount = is_var_shift ? i_src_a[4:0]
                                    : i_instr[SHAMT_MSB:SHAMT_LSB];
  assign lane.mode64 = i_mode64;

  shift_unit u_shift (
    .lane(lane.shift_mp)
  );

  arith_unit u_arith (
    .lane(lane.arith_mp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Result select and write-back stage

  logic done_reg;
  logic done_next;
  logic wb_en_reg;
  logic wb_en_next;
  logic [4:0] wb_idx_reg;
  logic [4:0] wb_idx_next;
  logic [63:0] wb_data_reg;
  logic [63:0] wb_data_next;
  logic ovf_reg;
  logic ovf_next;
  logic not_handled_reg;
  logic not_handled_next;
  logic [63:0] result;

  always_comb begin
    unique case (dec_op)
      OP_SIGNED_LESS_FLAG, OP_UNSIGNED_LESS_FLAG,
      OP_SIGNED_LESS_IMM_FLAG, OP_UNSIGNED_LESS_IMM_FLAG: result = lane.cmp_res;
      OP_DIFFERENCE_TRAP, OP_DIFFERENCE_NO_TRAP: result = lane.diff_res;
      default: result = lane.shift_res;
    endcase
  end

  always_comb begin
    done_next = i_valid;
    ovf_next = i_valid && lane.ovf;
    wb_en_next = i_valid && (dec_op != OP_NONE) && !lane.ovf;
    not_handled_next = i_valid && (dec_op == OP_NONE);
    wb_idx_next = is_imm_form ? i_instr[SRCB_MSB:SRCB_LSB] : i_instr[DST_MSB:DST_LSB];
    // Data only moves on a real write, so a trapped subtract leaves the bus quiet
    wb_data_next = wb_en_next ? result : wb_data_reg;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_reg <= 1'h0;
      wb_en_reg <= 1'h0;
      wb_idx_reg <= WB_IDX_RST;
      wb_data_reg <= WB_DATA_RST;
      ovf_reg <= 1'h0;
      not_handled_reg <= 1'h0;
    end else begin
      done_reg <= done_next;
      wb_en_reg <= wb_en_next;
      wb_idx_reg <= wb_idx_next;
      wb_data_reg <= wb_data_next;
      ovf_reg <= ovf_next;
      not_handled_reg <= not_handled_next;
    end
  end

  assign o_done = done_reg;
  assign o_wb_en = wb_en_reg;
  assign o_wb_idx = wb_idx_reg;
  assign o_wb_data = wb_data_reg;
  assign o_ovf_exc = ovf_reg;
  assign o_not_handled = not_handled_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks: reference values computed apart from the units

  logic [31:0] exp_left_shift_var;
  logic [31:0] exp_sra;
  logic [31:0] exp_srl;
  logic [31:0] exp_diff;
  logic exp_ovf;
  logic exp_slt;
  logic exp_signed_less_imm_flag;
  logic exp_unsigned_less_imm_flag;
  logic is_cmp;
  logic [31:0] exp_arith_right_shift_var;
  logic [31:0] exp_srl_imm;
  logic exp_unsigned_less_flag;
  logic exp_slt32;
  logic exp_slti32;
  logic exp_sltiu32;
  logic is_right_shift;

  assign exp_left_shift_var = i_src_b[31:0] << i_src_a[4:0];
  assign exp_sra = 32'($signed(i_src_b[31:0]) >>> i_instr[SHAMT_MSB:SHAMT_LSB]);
  assign exp_srl = i_src_b[31:0] >> i_src_a[4:0];
  assign exp_diff = i_src_a[31:0] - i_src_b[31:0];
  assign exp_ovf = (i_src_a[31] != i_src_b[31]) && (exp_diff[31] != i_src_a[31]);
  assign exp_slt = $signed(i_src_a) < $signed(i_src_b);
  assign exp_signed_less_imm_flag = $signed(i_src_a) < $signed(imm_sext);
  assign exp_unsigned_less_imm_flag = i_src_a < imm_sext;
  assign is_cmp = is_imm_form || (dec_op == OP_SIGNED_LESS_FLAG)
               || (dec_op == OP_UNSIGNED_LESS_FLAG);
  // Word-mode references look at the low halves only, as the slice does in 32-bit mode
  assign exp_arith_right_shift_var = 32'($signed(i_src_b[31:0]) >>> i_src_a[4:0]);
  assign exp_srl_imm = i_src_b[31:0] >> i_instr[SHAMT_MSB:SHAMT_LSB];
  assign exp_unsigned_less_flag = i_src_a < i_src_b;
  assign exp_slt32 = $signed(i_src_a[31:0]) < $signed(i_src_b[31:0]);
  assign exp_slti32 = $signed(i_src_a[31:0]) < $signed(imm_sext[31:0]);
  assign exp_sltiu32 = i_src_a[31:0] < imm_sext[31:0];
  assign is_right_shift = (dec_op == OP_LOGIC_RIGHT_SHIFT_IMM)
                       || (dec_op == OP_ARITH_RIGHT_SHIFT_IMM)
                       || (dec_op == OP_LOGIC_RIGHT_SHIFT_VAR)
                       || (dec_op == OP_ARITH_RIGHT_SHIFT_VAR);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  left_fill_a: assert property (
    i_valid && dec_op == OP_LEFT_SHIFT_VAR |=> o_wb_data[31:0] == $past(exp_left_shift_var))
    else $error("left shift word wrong");
  left_sext_a: assert property (
    i_valid && dec_op == OP_LEFT_SHIFT_VAR && i_mode64
    |=> o_wb_en && o_wb_data[63:32] == {32{o_wb_data[31]}})
    else $error("left shift not sign-extended");
  signed_flag_a: assert property (
    i_valid && dec_op == OP_SIGNED_LESS_FLAG && i_mode64
    |=> o_wb_data == {63'h0, $past(exp_slt)})
    else $error("signed compare result wrong");
  compare_no_trap_a: assert property (
    i_valid && is_cmp |=> !o_ovf_exc && o_wb_en)
    else $error("compare raised overflow");
  imm_signed_a: assert property (
    i_valid && dec_op == OP_SIGNED_LESS_IMM_FLAG && i_mode64
    |=> o_wb_data[0] == $past(exp_signed_less_imm_flag) && o_wb_idx == $past(i_instr[SRCB_MSB:SRCB_LSB]))
    else $error("immediate signed compare wrong");
  imm_unsigned_a: assert property (
    i_valid && dec_op == OP_UNSIGNED_LESS_IMM_FLAG && i_mode64
    |=> o_wb_data == {63'h0, $past(exp_unsigned_less_imm_flag)})
    else $error("immediate unsigned compare wrong");
  arith_fill_a: assert property (
    i_valid && dec_op == OP_ARITH_RIGHT_SHIFT_IMM |=> o_wb_data[31:0] == $past(exp_sra))
    else $error("arithmetic right shift wrong");
  logic_fill_a: assert property (
    i_valid && dec_op == OP_LOGIC_RIGHT_SHIFT_VAR |=> o_wb_data[31:0] == $past(exp_srl))
    else $error("logical right shift wrong");
  sub_trap_a: assert property (
    i_valid && dec_op == OP_DIFFERENCE_TRAP |=> o_ovf_exc == $past(exp_ovf))
    else $error("overflow detect wrong");
  trap_no_write_a: assert property (
    o_ovf_exc |-> !o_wb_en && $stable(o_wb_data))
    else $error("write on overflow");
  nontrap_diff_a: assert property (
    i_valid && dec_op == OP_DIFFERENCE_NO_TRAP
    |=> !o_ovf_exc && o_wb_en && o_wb_data[31:0] == $past(exp_diff))
    else $error("non-trapping subtract wrong");
  diff_sext_a: assert property (
    i_valid && dec_op == OP_DIFFERENCE_NO_TRAP && i_mode64
    |=> o_wb_data[63:32] == {32{o_wb_data[31]}})
    else $error("difference not sign-extended");
  dest_field_a: assert property (
    i_valid && opcode == OPC_REGISTER_OP_GROUP && funct == FN_SIGNED_LESS
    |=> o_wb_idx == $past(i_instr[DST_MSB:DST_LSB]))
    else $error("destination field wrong");
  one_cycle_a: assert property (
    i_valid |=> o_done ##1 (o_done == $past(i_valid)))
    else $error("result not one cycle later");

  // Remaining forms, word mode and the refusal path
  arith_var_a: assert property (
    i_valid && dec_op == OP_ARITH_RIGHT_SHIFT_VAR |=> o_wb_data[31:0] == $past(exp_arith_right_shift_var))
    else $error("variable arithmetic right shift wrong");
  logic_imm_a: assert property (
    i_valid && dec_op == OP_LOGIC_RIGHT_SHIFT_IMM |=> o_wb_data[31:0] == $past(exp_srl_imm))
    else $error("immediate logical right shift wrong");
  right_sext_a: assert property (
    i_valid && is_right_shift && i_mode64
    |=> o_wb_en && o_wb_data[63:32] == {32{o_wb_data[31]}})
    else $error("right shift not sign-extended");
  signed_word_a: assert property (
    i_valid && dec_op == OP_SIGNED_LESS_FLAG && !i_mode64
    |=> o_wb_data == {63'h0, $past(exp_slt32)})
    else $error("word signed compare wrong");
  imm_signed_word_a: assert property (
    i_valid && dec_op == OP_SIGNED_LESS_IMM_FLAG && !i_mode64
    |=> o_wb_data == {63'h0, $past(exp_slti32)})
    else $error("word immediate signed compare wrong");
  unsigned_flag_a: assert property (
    i_valid && dec_op == OP_UNSIGNED_LESS_FLAG && i_mode64
    |=> o_wb_data == {63'h0, $past(exp_unsigned_less_flag)})
    else $error("unsigned compare result wrong");
  unsigned_word_a: assert property (
    i_valid && dec_op == OP_UNSIGNED_LESS_IMM_FLAG && !i_mode64
    |=> o_wb_data == {63'h0, $past(exp_sltiu32)})
    else $error("word immediate unsigned compare wrong");
  trap_clean_a: assert property (
    i_valid && dec_op == OP_DIFFERENCE_TRAP && !exp_ovf
    |=> o_wb_en && o_wb_data[31:0] == $past(exp_diff))
    else $error("trapping subtract difference wrong");
  unhandled_a: assert property (
    i_valid && dec_op == OP_NONE |=> o_not_handled && !o_wb_en && !o_ovf_exc)
    else $error("unknown operation not refused");
  wb_index_a: assert property (
    i_valid && !is_imm_form |=> o_wb_idx == $past(i_instr[DST_MSB:DST_LSB]))
    else $error("write-back index wrong");
  quiet_idle_a: assert property (
    !i_valid |=> !o_done && !o_wb_en && !o_ovf_exc && !o_not_handled)
    else $error("pulse without instruction");
  one_outcome_a: assert property (
    o_done |-> $onehot({o_wb_en, o_ovf_exc, o_not_handled}))
    else $error("outcome pulses not exclusive");
  word_upper_a: assert property (
    i_valid && !i_mode64 && dec_op != OP_NONE |=> !o_wb_en || o_wb_data[63:32] == 32'h0)
    else $error("word mode upper half not zero");

  trap_seen_c: cover property (o_ovf_exc);
  left_zero_c: cover property (i_valid && dec_op == OP_LEFT_SHIFT_VAR && i_src_a[4:0] == 5'h0);
  cmp_overflow_c: cover property (i_valid && dec_op == OP_SIGNED_LESS_FLAG && exp_ovf);
  back_to_back_c: cover property (o_wb_en ##1 o_wb_en);
  imm_wrap_c: cover property (i_valid && is_imm_form && imm_sext[63]);

endmodule : shift_compare_subtract_unit

// [tb/wb_sink_model.sv]
// Write-back sink model: the register file that takes the slice's results
`timescale 1ns/1ps
module wb_sink_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_en,
  input wire logic [4:0] i_wb_idx,
  input wire logic [63:0] i_wb_data
);
  logic [63:0] regs [32];

  // Only a strobed write lands, so a suppressed write leaves the old value visible
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 32; k++) begin
        regs[k] <= 64'h0;
      end
    end else if (i_wb_en === 1'b1) begin
      regs[i_wb_idx] <= i_wb_data;
    end
  end
endmodule : wb_sink_model

// [tb/shift_compare_subtract_unit_tb.sv]
// Testbench: random and corner operations, queued predictions checked at the outputs
`timescale 1ns/1ps
module shift_compare_subtract_unit_tb;
  import scsu_pkg::*;
  typedef struct {logic wen; logic ovf; logic nh; logic [4:0] idx; logic [63:0] data; int cyc;} note_t;
  logic i_core_clk = 1'b0;
  logic i_rst_n, i_valid, i_mode64;
  logic [31:0] i_instr;
  logic [63:0] i_src_a, i_src_b, o_wb_data, last_data, a, b;
  logic o_done, o_wb_en, o_ovf_exc, o_not_handled;
  logic [4:0] o_wb_idx;
  logic [5:0] fns [11];
  logic [63:0] shadow [32];
  note_t notes [$];
  note_t nt;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  shift_compare_subtract_unit i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_valid(i_valid), .i_instr(i_instr), .i_src_a(i_src_a), .i_src_b(i_src_b),
    .i_mode64(i_mode64), .o_done(o_done), .o_wb_en(o_wb_en), .o_wb_idx(o_wb_idx),
    .o_wb_data(o_wb_data), .o_ovf_exc(o_ovf_exc), .o_not_handled(o_not_handled));
  wb_sink_model i_model (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wb_en(o_wb_en),
    .i_wb_idx(o_wb_idx), .i_wb_data(o_wb_data));

  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [63:0] wext(logic [31:0] w, logic m64);
    return m64 ? {{32{w[31]}}, w} : {32'h0, w};
  endfunction : wext

  // Sign-extending both sides in 32-bit mode keeps low-word order for both compares
  function automatic note_t predict(logic [31:0] ins, logic [63:0] a, logic [63:0] b, logic m64);
    note_t n;
    logic [5:0] fn;
    logic [4:0] s;
    logic [63:0] ax;
    logic [63:0] bx;
    logic [31:0] w;
    fn = ins[5:0];
    n = '{1'b1, 1'b0, 1'b0, ins[15:11], 64'h0, cyc};
    bx = (ins[31:26] == OPC_REGISTER_OP_GROUP) ? b : {{48{ins[15]}}, ins[15:0]};
    ax = m64 ? a : {{32{a[31]}}, a[31:0]};
    bx = m64 ? bx : {{32{bx[31]}}, bx[31:0]};
    s = fn[2] ? a[4:0] : ins[10:6];
    w = a[31:0] - b[31:0];
    case (ins[31:26])
      OPC_SIGNED_LESS_IMM: n = '{1'b1, 1'b0, 1'b0, ins[20:16], 64'($signed(ax) < $signed(bx)), cyc};
      OPC_UNSIGNED_LESS_IMM: n = '{1'b1, 1'b0, 1'b0, ins[20:16], 64'(ax < bx), cyc};
      OPC_REGISTER_OP_GROUP: begin
        case (fn)
          FN_LEFT_SHIFT_VAR: n.data = wext(b[31:0] << s, m64);
          FN_LOGIC_RIGHT_IMM, FN_LOGIC_RIGHT_VAR: n.data = wext(b[31:0] >> s, m64);
          FN_ARITH_RIGHT_IMM, FN_ARITH_RIGHT_VAR: n.data = wext($signed(b[31:0]) >>> s, m64);
          FN_SIGNED_LESS: n.data = 64'($signed(ax) < $signed(bx));
          FN_UNSIGNED_LESS: n.data = 64'(ax < bx);
          FN_DIFFERENCE_NO_TRAP: n.data = wext(w, m64);
          FN_DIFFERENCE_TRAP: begin
            n.data = wext(w, m64);
            n.ovf = (a[31] != b[31]) && (w[31] != a[31]);
          end
          default: n.nh = 1'b1;
        endcase
      end
      default: n.nh = 1'b1;
    endcase
    n.wen = !n.ovf && !n.nh;
    return n;
  endfunction : predict

  task automatic issue(logic [31:0] ins, logic [63:0] a, logic [63:0] b, logic m64);
    @(negedge i_core_clk);
    i_valid = 1'b1;
    i_instr = ins;
    i_src_a = a;
    i_src_b = b;
    i_mode64 = m64;
    notes.push_back(predict(ins, a, b, m64));
  endtask : issue

  task automatic idle();
    @(negedge i_core_clk);
    i_valid = 1'b0;
  endtask : idle

  function automatic logic [63:0] edgy();
    logic [31:0] lo;
    lo = ($urandom_range(2) == 0) ? {1'($urandom_range(1)), 31'h0} - $urandom_range(1) : $urandom;
    return {$urandom, lo};
  endfunction : edgy

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge i_core_clk) begin
    if (i_rst_n === 1'b1 && o_done !== 1'b0) begin
      if (notes.size() == 0) begin
        chk("o_done", 64'h0, 64'(o_done));
      end else begin
        nt = notes.pop_front();
        chk("done_cycle", 64'(nt.cyc + 1), 64'(cyc));
        chk("o_ovf_exc", 64'(nt.ovf), 64'(o_ovf_exc));
        chk("o_not_handled", 64'(nt.nh), 64'(o_not_handled));
        chk("o_wb_en", 64'(nt.wen), 64'(o_wb_en));
        if (nt.wen) begin
          last_data = nt.data;
          shadow[nt.idx] = nt.data;
        end
        chk("o_wb_data", last_data, o_wb_data);
        if (!nt.nh) chk("o_wb_idx", 64'(nt.idx), 64'(o_wb_idx));
      end
    end else if (i_rst_n === 1'b1) begin
      chk("idle_pulses", 64'h0, 64'({o_wb_en, o_ovf_exc, o_not_handled}));
      chk("held_data", last_data, o_wb_data);
    end
  end

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(92));
    {i_rst_n, i_valid, i_mode64, i_instr, i_src_a, i_src_b, last_data} = '0;
    foreach (shadow[k]) shadow[k] = 64'h0;
    fns = '{FN_LEFT_SHIFT_VAR, FN_LOGIC_RIGHT_IMM, FN_ARITH_RIGHT_IMM, FN_LOGIC_RIGHT_VAR,
      FN_ARITH_RIGHT_VAR, FN_SIGNED_LESS, FN_UNSIGNED_LESS, FN_DIFFERENCE_TRAP,
      FN_DIFFERENCE_NO_TRAP, OPC_SIGNED_LESS_IMM, OPC_UNSIGNED_LESS_IMM};
    repeat (6) @(posedge i_core_clk);
    chk("reset_outputs", 64'h0, 64'({o_done, o_wb_en, o_ovf_exc, o_not_handled, o_wb_idx}));
    chk("reset_data", 64'h0, o_wb_data);
    @(negedge i_core_clk);
    i_rst_n = 1'b1;
    // Every operation in both modes, boundary-heavy operands, back to back or spaced
    for (int m = 0; m < 2; m++) begin
      for (int f = 0; f < 11; f++) begin
        repeat (20) begin
          logic [31:0] ins;
          ins = $urandom;
          if (f < 9) begin
            ins[31:26] = OPC_REGISTER_OP_GROUP;
            ins[5:0] = fns[f];
          end else begin
            ins[31:26] = fns[f];
          end
          a = edgy();
          b = edgy();
          // Right shifts and subtracts get sign-extended words in 64-bit mode
          if (m == 1 && f != 0 && f != 5 && f != 6 && f < 9) begin
            a = {{32{a[31]}}, a[31:0]};
            b = {{32{b[31]}}, b[31:0]};
          end
          issue(ins, a, b, m[0]);
          if ($urandom_range(3) == 0) idle();
        end
      end
    end
    issue({11'h0, 5'h02, 5'h04, 5'h00, FN_LEFT_SHIFT_VAR}, 64'h20, 64'h12345678_9abcdef0, 1'b1);
    issue({11'h0, 5'h03, 5'h05, 5'h00, FN_DIFFERENCE_NO_TRAP}, 64'h1, 64'h2, 1'b1);
    issue({11'h0, 5'h03, 5'h05, 5'h00, FN_DIFFERENCE_TRAP}, 64'hffffffff_80000000, 64'h1, 1'b1);
    issue({11'h0, 5'h03, 5'h05, 5'h00, FN_DIFFERENCE_NO_TRAP}, 64'h7fffffff, 64'hffffffff_ffffffff, 1'b1);
    issue({11'h0, 5'h03, 5'h06, 5'h00, FN_SIGNED_LESS}, 64'h7fffffff, 64'hffffffff_80000000, 1'b0);
    issue({11'h0, 5'h03, 5'h07, 5'h00, 6'h3f}, 64'h1, 64'h2, 1'b0);
    issue({6'h3f, 26'h0}, 64'h1, 64'h2, 1'b0);
    repeat (3) idle();
    chk("pending_notes", 64'h0, 64'(notes.size()));
    foreach (shadow[k]) chk("reg_file", shadow[k], i_model.regs[k]);
    print_verdict();
  end
endmodule : shift_compare_subtract_unit_tb
